/* File: bil_map.svh */
`ifndef BIL_MAP_SVH
`define BIL_MAP_SVH
// ==========================================
// Clock rates and derived divider counts
`define BIL_CORE_HZ      100000000
`define BIL_QSPI_HZ      50000000
`define BIL_SPI_HZ       2500000
`define BIL_QSPI_HALF    (`BIL_CORE_HZ / (2 * `BIL_QSPI_HZ))
`define BIL_SPI_HALF     (`BIL_CORE_HZ / (2 * `BIL_SPI_HZ))
// ==========================================
// Times
`define BIL_IRST_US      15
`define BIL_IRST_CYC     (`BIL_IRST_US * (`BIL_CORE_HZ / 1000000))
`define BIL_LNK_EN_NS    2000
`define BIL_LNK_EN_CYC   (`BIL_LNK_EN_NS / (1000000000 / `BIL_CORE_HZ))
// ==========================================
// Image format
`define BIL_CRC_POLY     32'hEDB88320
`define BIL_CRC_INIT     32'hFFFFFFFF
`define BIL_CRC_SKIP     32'h0D15AB1E
`define BIL_NULL_CHAN    32'h0000FF02
`define BIL_RUN_ADDR     32'h00000000
`define BIL_READ_CMD     8'h03
`define BIL_READ_ADDR    24'h000000
`define BIL_END_TOK      8'h01
`define BIL_SEC_BOOT_BIT 5
// ==========================================
// Strap codes and link masks
`define BIL_SEL_QSPI     3'h0
`define BIL_SEL_SPI      3'h1
`define BIL_MASK_4       8'h01
`define BIL_MASK_5       8'hF0
`define BIL_MASK_6       8'h66
`define BIL_MASK_7       8'h0F
`endif

/* File: bil_pkg.sv */
package bil_pkg;
    typedef enum logic [2:0] {SRC_QSPI, SRC_SPI, SRC_SLV, SRC_LNK, SRC_OTP} bil_src_t;
    typedef enum logic [2:0] {
        PH_IRST, PH_LWAIT, PH_ACK, PH_LOAD, PH_ENDIN, PH_ENDOUT, PH_RUN, PH_FAIL
    } bil_phase_t;
    typedef enum logic [1:0] {PS_LEN, PS_PROG, PS_CRC, PS_DONE} bil_parse_t;
    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } bil_tok_t;
    // ==========================================
    // Link-side state
    typedef struct packed {
        bil_tok_t hold;
        logic     req;
        logic     ak1;
        logic     ak2;
        logic     tr1;
        logic     tr2;
        logic     done;
    } bil_lnk_t;
    // ==========================================
    // Core-side state
    typedef struct packed {
        bil_phase_t  ph;
        bil_src_t    src;
        bil_parse_t  ps;
        logic [15:0] tcnt;
        logic [2:0]  sel1;
        logic [2:0]  sel2;
        logic        pd;
        logic [7:0]  lnk_en;
        logic        chan0;
        logic        ss_n;
        logic        sclk;
        logic [4:0]  div;
        logic [5:0]  bits;
        logic        cmd;
        logic [31:0] cmd_sr;
        logic [2:0]  rises;
        logic [1:0]  smp;
        logic [7:0]  sh;
        logic [2:0]  sbits;
        logic [3:0]  dq1;
        logic [3:0]  dq2;
        logic        mi1;
        logic        mi2;
        logic [2:0]  sl1;
        logic [2:0]  sl2;
        logic        sclk_d;
        logic [15:0] oaddr;
        logic        ord;
        logic [31:0] oword;
        logic [2:0]  obytes;
        logic        pv;
        logic [7:0]  pb;
        logic [31:0] len;
        logic [31:0] rcrc;
        logic [31:0] crc;
        logic [31:0] addr;
        logic [1:0]  bi;
        logic        we;
        logic [7:0]  wd;
        logic [31:0] wa;
        logic        ok;
        logic [31:0] ackw;
        logic [1:0]  ai;
        logic        rq1;
        logic        rq2;
        logic        seen;
        logic        txreq;
        logic        dn1;
        logic        dn2;
    } bil_core_t;
endpackage

/* File: bil_loader.sv */
`timescale 1ns/1ps
`include "bil_map.svh"

// ==========================================
// Byte FIFO, power-of-two depth
module bil_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Fill side
    input  wire logic                   in_valid,
    input  wire logic [W-1:0]           in_data,
    output logic                        in_ready,
    // Drain side
    output logic                        out_valid,
    output logic [W-1:0]                out_data,
    input  wire logic                   out_ready,
    output logic [$clog2(DEPTH):0]      level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } bil_fptr_t;
    bil_fptr_t    st_reg;
    bil_fptr_t    st_next;
    logic [W-1:0] mem [DEPTH];
    logic         push;

    assign level     = st_reg.wp - st_reg.rp;
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data  = mem[st_reg.rp[AW-1:0]];
    assign push      = in_valid && in_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st_reg.wp[AW-1:0]] <= in_data;
        end
    end
endmodule // bil_fifo

// ==========================================
// Boot image loader
module bil_loader #(
    parameter logic [15:0] IRST_CYC = 16'(`BIL_IRST_CYC),
    parameter int          DEPTH    = 32
) (
    // Clocks and reset
    input  wire logic          core_clk,
    input  wire logic          lnk_clk,
    input  wire logic          rst,
    // Straps and security
    input  wire logic          boot_sel_bit0,
    input  wire logic          boot_sel_bit1,
    input  wire logic          boot_sel_bit2,
    input  wire logic [31:0]   sec_reg,
    output logic               gpio_pd_en,
    output bil_pkg::bil_src_t  boot_src,
    // Flash master pins
    output logic               spi_ss_n,
    output logic               spi_sclk,
    output logic               spi_pins_en,
    output logic [3:0]         spi_dq_o,
    output logic [3:0]         spi_dq_oe,
    input  wire logic [3:0]    spi_dq_i,
    input  wire logic          spi_miso_i,
    // Slave pins
    input  wire logic          slv_ss_n,
    input  wire logic          slv_sclk,
    input  wire logic          slv_mosi,
    // OTP read port
    output logic               otp_rd,
    output logic [15:0]        otp_addr,
    input  wire logic          otp_valid,
    input  wire logic [31:0]   otp_rdata,
    // Links: enables on core_clk, tokens on lnk_clk
    output logic [7:0]         lnk_en,
    output logic [7:0]         lnk_pd_en,
    output logic               chan0_alloc,
    input  wire logic          lnk_rx_valid,
    input  wire bil_pkg::bil_tok_t lnk_rx_tok,
    output logic               lnk_rx_ready,
    output logic               lnk_tx_valid,
    output bil_pkg::bil_tok_t  lnk_tx_tok,
    input  wire logic          lnk_tx_ready,
    // RAM write port
    output logic               mem_we,
    output logic [31:0]        mem_addr,
    output logic [7:0]         mem_wdata,
    input  wire logic          mem_ready,
    // Execution
    output logic               run,
    output logic [31:0]        run_addr,
    output logic               boot_fail
);
    import bil_pkg::*;
    localparam int LW = $clog2(DEPTH) + 1;

    bil_core_t    s;
    bil_core_t    n;
    bil_lnk_t     l;
    bil_lnk_t     l_n;
    logic         tokv;
    logic         quad;
    logic         room;
    logic [4:0]   half;
    logic [7:0]   nb;
    logic         fo_v;
    logic         fo_rdy;
    logic [7:0]   fo_b;
    logic         fi_rdy;
    logic [LW-1:0] fifo_lvl;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] lnk_mask(input logic [1:0] code);
        case (code)
            2'h0:    lnk_mask = `BIL_MASK_4;
            2'h1:    lnk_mask = `BIL_MASK_5;
            2'h2:    lnk_mask = `BIL_MASK_6;
            default: lnk_mask = `BIL_MASK_7;
        endcase
    endfunction

    bil_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (s.pv),
        .in_data   (s.pb),
        .in_ready  (fi_rdy),
        .out_valid (fo_v),
        .out_data  (fo_b),
        .out_ready (fo_rdy),
        .level     (fifo_lvl)
    );

    // ==========================================
    // Outputs
    assign tokv        = s.rq2 != s.seen;
    assign quad        = s.src == SRC_QSPI;
    assign half        = quad ? 5'(`BIL_QSPI_HALF - 1) : 5'(`BIL_SPI_HALF - 1);
    // Leaves a slot for the byte still in the sampling pipe
    assign room        = fifo_lvl <= LW'(DEPTH - 3) && !s.pv;
    assign fo_rdy      = s.ps != PS_DONE && !(s.we && !mem_ready);
    assign gpio_pd_en  = s.pd;
    assign lnk_en      = s.lnk_en;
    assign lnk_pd_en   = s.pd ? 8'hFF : ~s.lnk_en;
    assign chan0_alloc = s.chan0;
    assign boot_src    = s.src;
    assign spi_ss_n    = s.ss_n;
    assign spi_sclk    = s.sclk;
    assign spi_pins_en = !s.ss_n;
    assign spi_dq_o    = {3'h0, s.cmd ? s.cmd_sr[31] : 1'b0};
    assign spi_dq_oe   = {3'h0, !s.ss_n && (s.cmd || s.src == SRC_SPI)};
    assign otp_rd      = s.ord;
    assign otp_addr    = s.oaddr;
    assign mem_we      = s.we;
    assign mem_addr    = s.wa;
    assign mem_wdata   = s.wd;
    assign run         = s.ph == PH_RUN;
    assign run_addr    = `BIL_RUN_ADDR;
    assign boot_fail   = s.ph == PH_FAIL;
    assign lnk_rx_ready = l.req == l.ak2;
    assign lnk_tx_valid = l.tr2 != l.done;
    assign lnk_tx_tok  = '{ctrl: 1'b1, data: `BIL_END_TOK};

    // ==========================================
    // Core next state
    always_comb begin
        n = s;
        nb = 8'h00;
        n.sel1 = {boot_sel_bit2, boot_sel_bit1, boot_sel_bit0};
        n.sel2 = s.ph == PH_IRST ? s.sel1 : s.sel2;
        n.dq1 = spi_dq_i;
        n.dq2 = s.dq1;
        n.mi1 = spi_miso_i;
        n.mi2 = s.mi1;
        n.sl1 = {slv_ss_n, slv_sclk, slv_mosi};
        n.sl2 = s.sl1;
        n.sclk_d = s.sl2[1];
        n.rq1 = l.req;
        n.rq2 = s.rq1;
        n.dn1 = l.done;
        n.dn2 = s.dn1;
        n.pv = s.pv && !fi_rdy;
        n.we = s.we && !mem_ready;
        n.smp = {s.smp[0], 1'b0};
        case (s.ph)
            PH_IRST: begin
                n.tcnt = s.tcnt + 16'h0001;
                if (s.tcnt == IRST_CYC - 16'h0001) begin
                    n.pd = 1'b0;
                    n.tcnt = 16'h0000;
                    n.ph = PH_LOAD;
                    if (sec_reg[`BIL_SEC_BOOT_BIT]) begin
                        n.src = SRC_OTP;
                    end else if (s.sel2[2]) begin
                        n.src = SRC_LNK;
                        n.ph = PH_LWAIT;
                    end else if (s.sel2 == `BIL_SEL_QSPI) begin
                        n.src = SRC_QSPI;
                    end else if (s.sel2 == `BIL_SEL_SPI) begin
                        n.src = SRC_SPI;
                    end else begin
                        n.src = SRC_SLV;
                    end
                end
            end
            PH_LWAIT: begin
                n.tcnt = s.tcnt + 16'h0001;
                if (s.tcnt == 16'(`BIL_LNK_EN_CYC - 1)) begin
                    n.lnk_en = lnk_mask(s.sel2[1:0]);
                    n.chan0 = 1'b1;
                    n.ph = PH_ACK;
                end
            end
            PH_ACK: begin
                if (tokv) begin
                    n.seen = s.rq2;
                    if (!l.hold.ctrl) begin
                        n.ackw[8*s.ai +: 8] = l.hold.data;
                        n.ai = s.ai + 2'h1;
                        if (s.ai == 2'h3) begin
                            n.ph = PH_LOAD;
                        end
                    end
                end
            end
            PH_LOAD: begin
                if (s.ps == PS_DONE && !s.we) begin
                    n.ph = (s.src == SRC_LNK) ? PH_ENDIN : (s.ok ? PH_RUN : PH_FAIL);
                end
            end
            PH_ENDIN: begin
                if (tokv) begin
                    n.seen = s.rq2;
                    if (l.hold.ctrl && l.hold.data == `BIL_END_TOK) begin
                        n.ph = PH_ENDOUT;
                        if (s.ackw != `BIL_NULL_CHAN) begin
                            n.txreq = !s.txreq;
                        end
                    end
                end
            end
            PH_ENDOUT: begin
                if (s.dn2 == s.txreq) begin
                    n.chan0 = 1'b0;
                    n.ph = s.ok ? PH_RUN : PH_FAIL;
                end
            end
            PH_RUN: begin
                n.ph = PH_RUN;
            end
            PH_FAIL: begin
                n.ph = PH_FAIL;
            end
            default: begin
                n.ph = PH_FAIL;
            end
        endcase

        // Flash master, mode 0: shift on fall, sample on rise
        if ((quad || s.src == SRC_SPI) && s.ph == PH_LOAD) begin
            if (s.ps == PS_DONE) begin
                n.ss_n = 1'b1;
                n.sclk = 1'b0;
            end else if (s.ss_n) begin
                n.ss_n = 1'b0;
                n.cmd = 1'b1;
                n.cmd_sr = {`BIL_READ_CMD, `BIL_READ_ADDR};
                n.bits = 6'h00;
                n.div = 5'h00;
                n.rises = 3'h0;
                n.sbits = 3'h0;
            end else if (s.div != half) begin
                n.div = s.div + 5'h01;
            end else begin
                n.div = 5'h00;
                if (!s.sclk) begin
                    // Clock pauses at byte boundary while the FIFO is nearly full
                    if (s.cmd || s.rises != 3'h0 || room) begin
                        n.sclk = 1'b1;
                        if (s.cmd) begin
                            n.bits = s.bits + 6'h01;
                        end else begin
                            n.smp[0] = 1'b1;
                            n.rises = (s.rises == (quad ? 3'h1 : 3'h7)) ? 3'h0 : s.rises + 3'h1;
                        end
                    end
                end else begin
                    n.sclk = 1'b0;
                    if (s.cmd) begin
                        if (s.bits == 6'h20) begin
                            n.cmd = 1'b0;
                        end else begin
                            n.cmd_sr = s.cmd_sr << 1;
                        end
                    end
                end
            end
            // Pins seen two cycles late through the synchroniser
            if (s.smp[1]) begin
                nb = quad ? {s.dq2, s.sh[7:4]} : {s.mi2, s.sh[7:1]};
                n.sh = nb;
                n.sbits = s.sbits + 3'h1;
                if (s.sbits == (quad ? 3'h1 : 3'h7)) begin
                    n.sbits = 3'h0;
                    n.pv = 1'b1;
                    n.pb = nb;
                end
            end
        end

        // Slave: both modes sample on the rising edge
        if (s.src == SRC_SLV && s.ph == PH_LOAD && s.ps != PS_DONE) begin
            if (s.sl2[2]) begin
                n.sbits = 3'h0;
            end else if (s.sl2[1] && !s.sclk_d) begin
                nb = {s.sl2[0], s.sh[7:1]};
                n.sh = nb;
                n.sbits = s.sbits + 3'h1;
                if (s.sbits == 3'h7) begin
                    n.sbits = 3'h0;
                    // No back-pressure toward an external master: overrun drops
                    if (!n.pv) begin
                        n.pv = 1'b1;
                        n.pb = nb;
                    end
                end
            end
        end

        // OTP words split into bytes, low byte first
        if (s.src == SRC_OTP && s.ph == PH_LOAD && s.ps != PS_DONE) begin
            if (s.ord) begin
                if (otp_valid) begin
                    n.ord = 1'b0;
                    n.oword = otp_rdata;
                    n.obytes = 3'h4;
                    n.oaddr = s.oaddr + 16'h0001;
                end
            end else if (s.obytes == 3'h0) begin
                n.ord = 1'b1;
            end else if (!n.pv) begin
                n.pv = 1'b1;
                n.pb = s.oword[7:0];
                n.oword = {8'h00, s.oword[31:8]};
                n.obytes = s.obytes - 3'h1;
            end
        end

        // Link data tokens into the FIFO
        if (s.src == SRC_LNK && s.ph == PH_LOAD && tokv && !l.hold.ctrl
                && !n.pv && s.ps != PS_DONE) begin
            n.seen = s.rq2;
            n.pv = 1'b1;
            n.pb = l.hold.data;
        end

        // Image parser and RAM writer
        if (fo_v && fo_rdy) begin
            case (s.ps)
                PS_LEN: begin
                    n.len[8*s.bi +: 8] = fo_b;
                    n.crc = crc_byte(s.crc, fo_b);
                    n.bi = s.bi + 2'h1;
                    if (s.bi == 2'h3) begin
                        n.ps = ({fo_b, s.len[23:0]} == 32'h0) ? PS_CRC : PS_PROG;
                    end
                end
                PS_PROG: begin
                    n.we = 1'b1;
                    n.wd = fo_b;
                    n.wa = `BIL_RUN_ADDR + s.addr;
                    n.addr = s.addr + 32'h1;
                    n.crc = crc_byte(s.crc, fo_b);
                    if (s.addr + 32'h1 == {s.len[29:0], 2'h0}) begin
                        n.ps = PS_CRC;
                    end
                end
                PS_CRC: begin
                    n.rcrc[8*s.bi +: 8] = fo_b;
                    n.bi = s.bi + 2'h1;
                    if (s.bi == 2'h3) begin
                        n.ps = PS_DONE;
                        n.ok = {fo_b, s.rcrc[23:0]} == `BIL_CRC_SKIP
                            || {fo_b, s.rcrc[23:0]} == ~s.crc;
                    end
                end
                default: begin
                    n.ps = PS_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.ph <= PH_IRST;
            s.src <= SRC_QSPI;
            s.ps <= PS_LEN;
            s.pd <= 1'b1;
            s.ss_n <= 1'b1;
            s.crc <= `BIL_CRC_INIT;
        end else begin
            s <= n;
        end
    end

    // ==========================================
    // Link domain: toggle handshakes both ways
    always_comb begin
        l_n = l;
        l_n.ak1 = s.seen;
        l_n.ak2 = l.ak1;
        l_n.tr1 = s.txreq;
        l_n.tr2 = l.tr1;
        if (lnk_rx_valid && lnk_rx_ready) begin
            l_n.hold = lnk_rx_tok;
            l_n.req = !l.req;
        end
        if (lnk_tx_valid && lnk_tx_ready) begin
            l_n.done = !l.done;
        end
    end

    always_ff @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            l <= '0;
        end else begin
            l <= l_n;
        end
    end
endmodule // bil_loader

/* File: bil_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker
module bil_chk (
    // Clocks, reset and levels
    input wire logic              core_clk, lnk_clk, rst, gpio_pd_en, run, boot_fail,
    // Handshakes
    input wire logic              mem_we, mem_ready, otp_rd, otp_valid, lnk_tx_valid, lnk_tx_ready,
    // Data
    input wire logic [7:0]        lnk_en, lnk_pd_en, mem_wdata,
    input wire logic [31:0]       run_addr, mem_addr,
    input wire logic [15:0]       otp_addr,
    input wire bil_pkg::bil_tok_t lnk_tx_tok
);
    import bil_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A stalled RAM write must not move under the memory
    sequence wr_wait; mem_we && !mem_ready; endsequence
    sequence wr_same; mem_we && $stable(mem_addr) && $stable(mem_wdata); endsequence
    chk_pd_reset: assert property (gpio_pd_en |-> lnk_pd_en == 8'hFF)
        else $error("pull-downs off in reset");
    chk_pd_links: assert property (!gpio_pd_en |-> lnk_pd_en == ~lnk_en)
        else $error("link pull-downs wrong");
    chk_run_addr: assert property (run |-> run_addr == 32'h00000000)
        else $error("start address not zero");
    chk_run_keep: assert property (run |=> run && !boot_fail)
        else $error("run dropped or fail raised");
    chk_fail_block: assert property (boot_fail |=> boot_fail && !run)
        else $error("program started after failed check");
    chk_wr_hold: assert property (wr_wait |=> wr_same)
        else $error("RAM write changed while stalled");
    chk_otp_hold: assert property (otp_rd && !otp_valid |=> otp_rd && $stable(otp_addr))
        else $error("OTP request dropped or moved");
    chk_end_code: assert property (@(posedge lnk_clk) disable iff (rst)
        lnk_tx_valid |-> lnk_tx_tok.ctrl && lnk_tx_tok.data == 8'h01)
        else $error("outgoing token is not END");
    chk_end_hold: assert property (@(posedge lnk_clk) disable iff (rst)
        lnk_tx_valid && !lnk_tx_ready |=> lnk_tx_valid)
        else $error("END token withdrawn");
endmodule // bil_chk

/* File: bil_peer.sv */
`timescale 1ns/1ps
// ==========================================
// Link peer: feeds tokens, takes END back
module bil_peer (
    // Link side
    input wire logic              lnk_clk, rx_ready, tx_valid, stall,
    input wire bil_pkg::bil_tok_t tx_tok,
    output logic                  rx_valid, tx_ready,
    output bil_pkg::bil_tok_t     rx_tok
);
    import bil_pkg::*;
    int   ends;
    logic rdy_s;
    initial begin
        rx_valid = 1'b0;
        rx_tok = '0;
        tx_ready = 1'b0;
        ends = 0;
    end
    always @(negedge lnk_clk) rdy_s <= rx_ready;
    always @(posedge lnk_clk) begin
        if (tx_valid && tx_ready && tx_tok.ctrl) ends <= ends + 1;
        tx_ready <= !stall;
    end
    task automatic send(input logic c, input logic [7:0] d);
        @(posedge lnk_clk) #1;
        rx_valid = 1'b1;
        rx_tok = '{c, d};
        for (int i = 0; i < 99; i++) begin
            @(posedge lnk_clk);
            if (rdy_s) break;
        end
        #1;
        rx_valid = 1'b0;
        rx_tok = ~rx_tok;
    endtask
endmodule // bil_peer

/* File: boot_image_loader_tb.sv */
`timescale 1ns/1ps
module boot_image_loader_tb;
    import bil_pkg::*;
    logic core_clk = 0, lnk_clk = 0, rst = 1, mem_ready = 0, otp_valid = 0, stall = 0;
    logic run, boot_fail, mem_we, otp_rd, gpio_pd_en, chan0_alloc, rx_valid, rx_ready;
    logic tx_valid, tx_ready;
    logic [2:0] sel = 3'h4;
    logic ss = 1, sck = 0, mosi = 0;
    logic [31:0] sec_reg = 0, otp_rdata = 0, run_addr, mem_addr;
    logic [15:0] otp_addr;
    logic [7:0] lnk_en, lnk_pd_en, mem_wdata, ram [16], img [16];
    bil_tok_t rx_tok, tx_tok;
    bil_src_t boot_src;
    int error_cnt = 0, n_tests = 0;
    always #5 core_clk = ~core_clk;
    initial begin
        #3;
        forever #80 lnk_clk = ~lnk_clk;
    end
    bil_loader #(.IRST_CYC(16'h0014)) i_bil_loader (.core_clk, .lnk_clk, .rst,
        .boot_sel_bit0(sel[0]), .boot_sel_bit1(sel[1]), .boot_sel_bit2(sel[2]), .sec_reg,
        .gpio_pd_en, .boot_src, .spi_ss_n(), .spi_sclk(), .spi_pins_en(), .spi_dq_o(),
        .spi_dq_oe(), .spi_dq_i(4'h0), .spi_miso_i(1'b0), .slv_ss_n(ss), .slv_sclk(sck),
        .slv_mosi(mosi), .otp_rd, .otp_addr, .otp_valid, .otp_rdata, .lnk_en, .lnk_pd_en,
        .chan0_alloc, .lnk_rx_valid(rx_valid), .lnk_rx_tok(rx_tok), .lnk_rx_ready(rx_ready),
        .lnk_tx_valid(tx_valid), .lnk_tx_tok(tx_tok), .lnk_tx_ready(tx_ready), .mem_we,
        .mem_addr, .mem_wdata, .mem_ready, .run, .run_addr, .boot_fail);
    bil_peer i_bil_peer (.lnk_clk, .rx_ready, .tx_valid, .stall, .tx_tok, .rx_valid,
        .tx_ready, .rx_tok);
    // RAM stalls every other cycle
    always @(negedge core_clk) begin
        mem_ready <= ~mem_ready;
        otp_valid <= otp_rd && !otp_valid;
        otp_rdata <= {img[otp_addr[1:0]*4+3], img[otp_addr[1:0]*4+2],
                      img[otp_addr[1:0]*4+1], img[otp_addr[1:0]*4]};
    end
    always @(posedge core_clk) if (mem_we && mem_ready) ram[mem_addr[3:0]] <= mem_wdata;
    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] crc(input int n);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n; i++) begin
            c ^= img[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction
    // m: 0 good CRC, 1 skip value, 2 wrong CRC
    task automatic mk(input int m);
        logic [31:0] c;
        for (int i = 0; i < 12; i++) img[i] = i == 0 ? 8'h02 : i < 4 ? 8'h00 : 8'(i * 37);
        c = crc(12);
        if (m == 1) c = 32'h0D15AB1E;
        if (m == 2) c = ~c;
        for (int i = 0; i < 4; i++) img[12+i] = c[8*i +: 8];
    endtask
    task automatic boot(input logic [2:0] s, input logic [31:0] sr, input bil_src_t src);
        @(negedge core_clk);
        rst = 1;
        sel = s;
        sec_reg = sr;
        stall = 0;
        ram = '{default: 8'h00};
        i_bil_peer.ends = 0;
        repeat (8) @(negedge core_clk);
        rst = 0;
        repeat (30) @(negedge core_clk);
        chk("source", 32'(src), 32'(boot_src));
    endtask
    task automatic wait_done;
        for (int i = 0; i < 20000 && run !== 1'b1 && boot_fail !== 1'b1; i++) @(negedge core_clk);
        if (run !== 1'b1 && boot_fail !== 1'b1) begin
            chk("finish", 1, 0);
            test_done;
        end
    endtask
    task automatic link(input logic [7:0] en, input logic [31:0] ack);
        for (int i = 0; i < 400 && lnk_en === 8'h00; i++) @(negedge core_clk);
        chk("links", {24'h0, en}, {24'h0, lnk_en});
        chk("chan0", 1, {31'h0, chan0_alloc});
        for (int i = 0; i < 4; i++) i_bil_peer.send(1'b0, ack[8*i +: 8]);
        for (int i = 0; i < 16; i++) i_bil_peer.send(1'b0, img[i]);
        i_bil_peer.send(1'b1, 8'h01);
    endtask
    task automatic chk_ram;
        for (int i = 0; i < 8; i++) chk("ram", {24'h0, img[4+i]}, {24'h0, ram[i]});
    endtask
    task automatic t_straps;
        bil_src_t s [4] = '{SRC_QSPI, SRC_SPI, SRC_SLV, SRC_SLV};
        for (int i = 0; i < 4; i++) boot(3'(i), 0, s[i]);
    endtask
    task automatic t_link_ack;
        mk(0);
        boot(3'h4, 0, SRC_LNK);
        sel = 3'h3;
        stall = 1;
        link(8'h01, 32'h00000102);
        repeat (60) @(negedge core_clk);
        stall = 0;
        wait_done;
        chk("run", 1, {31'h0, run});
        chk("source held", 32'(SRC_LNK), 32'(boot_src));
        chk("end back", 1, i_bil_peer.ends);
        chk_ram;
    endtask
    task automatic t_link_bad;
        mk(2);
        boot(3'h7, 0, SRC_LNK);
        link(8'h0F, 32'h0000FF02);
        wait_done;
        repeat (40) @(negedge core_clk);
        chk("fail", 1, {31'h0, boot_fail});
        chk("no end", 0, i_bil_peer.ends);
    endtask
    task automatic t_link_skip;
        logic [7:0] en [2] = '{8'hF0, 8'h66};
        mk(1);
        for (int i = 0; i < 2; i++) begin
            boot(3'(5 + i), 0, SRC_LNK);
            link(en[i], 32'h0000FF02);
            wait_done;
            chk("skip run", 1, {31'h0, run});
        end
    endtask
    task automatic t_otp;
        mk(0);
        boot(3'h4, 32'h00000020, SRC_OTP);
        wait_done;
        chk("otp run", 1, {31'h0, run});
        chk("otp links", 0, {24'h0, lnk_en});
        chk_ram;
    endtask
    task automatic t_slave;
        mk(0);
        boot(3'h2, 0, SRC_SLV);
        for (int i = 0; i < 128; i++) begin
            {ss, mosi} = {1'b0, img[i/8][i%8]};
            repeat (4) @(negedge core_clk) sck = 1;
            repeat (4) @(negedge core_clk) sck = 0;
        end
        wait_done;
        chk("slave run", 1, {31'h0, run});
        chk_ram;
    endtask
    initial begin
        t_straps;
        t_link_ack;
        t_link_bad;
        t_link_skip;
        t_otp;
        t_slave;
        test_done;
    end
endmodule // boot_image_loader_tb
bind bil_loader bil_chk i_bil_chk (.core_clk, .lnk_clk, .rst, .gpio_pd_en, .run, .boot_fail,
    .mem_we, .mem_ready, .otp_rd, .otp_valid, .lnk_tx_valid, .lnk_tx_ready, .lnk_en,
    .lnk_pd_en, .mem_wdata, .run_addr, .mem_addr, .otp_addr, .lnk_tx_tok);
